// ==== rtl/crwap_core_regs.sv ====
`timescale 1ns/10ps
// Contract
// - thirty-two byte working registers, own space
// - single-cycle register read and write
// - immediate ops reach only R16-R31
// - R26-R31 form three 16-bit pointers
// - top pointer also addresses program memory
// - pointers support displacement, increment, decrement
// - 16-bit registers use byte staging latch
// - low write loads latch only
// - high write commits latch and byte together
// - low read stages high byte
// - high read returns staged byte
// - protected actions need valid key first
// - io unlock ends on write, nvm, sleep
// - spm unlock ends on nvm, sleep
// - no interrupts while unlocked
// - pending requests serviced after unlock
// - keys are D8 io and 9D spm
// - key bit0 io, bit1 spm, rest zero
module crwap_core_regs (
   // clock and reset
   input  wire logic                       clock_in,
   input  wire logic                       nrst_in,
   // working register port
   input  wire crwap_pkg::crwap_rf_req_t   rf_req_in,
   // pointer operation
   input  wire crwap_pkg::crwap_ptr_req_t  ptr_req_in,
   // i/o register bus
   input  wire crwap_pkg::crwap_bus_req_t  bus_req_in,
   // core activity
   input  wire crwap_pkg::crwap_core_evt_t evt_in,
   input  wire logic                       irq_pending_in,
   // register file read data
   output logic [7:0]                      rd_a_out,
   output logic [7:0]                      rd_b_out,
   output logic                            rf_refused_out,
   // pointer results
   output logic [15:0]                     ptr_addr_out,
   output logic [15:0]                     prog_addr_out,
   // i/o read data
   output logic [7:0]                      bus_rdata_out,
   // protection and interrupt gating
   output logic                            io_unlock_out,
   output logic                            spm_unlock_out,
   output logic                            prot_io_accept_out,
   output logic                            nvm_cmd_accept_out,
   output logic                            irq_take_out,
   // visible state
   output logic [15:0]                     stack_top_pointer_out,
   output logic [7:0]                      result_flags_out
);
   logic [7:0]  regs_q [crwap_pkg::NUM_REGS];
   logic [7:0]  regs_d [crwap_pkg::NUM_REGS];
   logic [7:0]  rd_a_q;
   logic [7:0]  rd_a_d;
   logic [7:0]  rd_b_q;
   logic [7:0]  rd_b_d;
   logic        refused_q;
   logic        refused_d;
   logic [15:0] ptr_addr_q;
   logic [15:0] ptr_addr_d;
   logic [15:0] prog_addr_q;
   logic [15:0] prog_addr_d;
   logic [7:0]  flags_q;
   logic [7:0]  flags_d;
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;
   logic [2:0]  cnt_q;
   logic [2:0]  cnt_d;
   crwap_pkg::crwap_unlock_t mode_q;
   crwap_pkg::crwap_unlock_t mode_d;
   logic        acc_io_q;
   logic        acc_io_d;
   logic        acc_nvm_q;
   logic        acc_nvm_d;
   logic        irq_q;
   logic        irq_d;
   // window flags registered so the unlock outputs come from flops
   logic        io_q;
   logic        io_d;
   logic        spm_q;
   logic        spm_d;
   logic [15:0] sp_value;
   logic [7:0]  sp_rdata;
   logic        sp_lo_wr;
   logic        sp_hi_wr;
   logic        sp_lo_rd;
   logic        sp_hi_rd;

   function automatic logic [4:0] PTR_LO_IDX(input logic [1:0] sel);
      case (sel)
         2'h0:    return crwap_pkg::PTR_X_LO;
         2'h1:    return crwap_pkg::PTR_Y_LO;
         default: return crwap_pkg::PTR_Z_LO;
      endcase
   endfunction

   function automatic logic HIT(input crwap_pkg::crwap_bus_req_t req, input logic [5:0] ofs);
      return req.addr == ofs;
   endfunction

   assign sp_lo_wr = bus_req_in.wr && HIT(bus_req_in, crwap_pkg::OFS_SP_LO);
   assign sp_hi_wr = bus_req_in.wr && HIT(bus_req_in, crwap_pkg::OFS_SP_HI);
   assign sp_lo_rd = bus_req_in.rd && HIT(bus_req_in, crwap_pkg::OFS_SP_LO);
   assign sp_hi_rd = bus_req_in.rd && HIT(bus_req_in, crwap_pkg::OFS_SP_HI);

   crwap_wide_stage u_sp (
      .clock_in     (clock_in),
      .nrst_in      (nrst_in),
      .lo_wr_in     (sp_lo_wr),
      .hi_wr_in     (sp_hi_wr),
      .lo_rd_in     (sp_lo_rd),
      .hi_rd_in     (sp_hi_rd),
      .wdata_in     (bus_req_in.wdata),
      .reset_val_in (crwap_pkg::SP_RESET),
      .value_out    (sp_value),
      .rdata_out    (sp_rdata)
   );

   // working registers and pointers
   always_comb begin
      logic [4:0]  lo_idx;
      logic [15:0] ptr;
      logic [15:0] eff;
      logic        ok;
      lo_idx = PTR_LO_IDX(ptr_req_in.sel);
      ptr    = 16'h0000;
      eff    = 16'h0000;
      ok     = 1'b0;
      for (int i = 0; i < crwap_pkg::NUM_REGS; i++) begin
         regs_d[i] = regs_q[i];
      end
      // read data is the registered operand of the requested index
      rd_a_d = regs_q[rf_req_in.rd_a_idx];
      rd_b_d = regs_q[rf_req_in.rd_b_idx];
      ok = !rf_req_in.imm_op || (rf_req_in.wr_idx >= crwap_pkg::IMM_BASE);
      refused_d = rf_req_in.wr_en && !ok;
      if (rf_req_in.wr_en && ok) begin
         regs_d[rf_req_in.wr_idx] = rf_req_in.wr_data;
      end
      ptr = {regs_q[lo_idx + 5'h01], regs_q[lo_idx]};
      eff = ptr;
      ptr_addr_d = ptr_addr_q;
      if (ptr_req_in.en) begin
         case (ptr_req_in.mode)
            crwap_pkg::CRWAP_PTR_DISP: begin
               eff = ptr + {10'h000, ptr_req_in.disp};
            end
            crwap_pkg::CRWAP_PTR_POSTINC: begin
               {regs_d[lo_idx + 5'h01], regs_d[lo_idx]} = ptr + 16'h0001;
            end
            crwap_pkg::CRWAP_PTR_PREDEC: begin
               eff = ptr - 16'h0001;
               {regs_d[lo_idx + 5'h01], regs_d[lo_idx]} = eff;
            end
            default: begin
               eff = ptr;
            end
         endcase
         ptr_addr_d = eff;
      end
      // Z always feeds the program memory address
      prog_addr_d = {regs_q[crwap_pkg::PTR_Z_LO + 5'h01], regs_q[crwap_pkg::PTR_Z_LO]};
   end

   // unlock window and i/o registers
   always_comb begin
      logic io_end;
      logic spm_end;
      mode_d  = mode_q;
      cnt_d   = cnt_q;
      flags_d = flags_q;
      io_end  = evt_in.io_or_ram_wr || evt_in.nvm_access || evt_in.sleep_exec;
      spm_end = evt_in.nvm_access || evt_in.sleep_exec;
      // protected actions pass only inside their own window
      acc_io_d  = evt_in.prot_io_wr && (mode_q == crwap_pkg::CRWAP_UNLOCK_IO);
      acc_nvm_d = evt_in.nvm_cmd_wr && (mode_q == crwap_pkg::CRWAP_UNLOCK_SPM);
      if (mode_q != crwap_pkg::CRWAP_UNLOCK_NONE) begin
         if ((mode_q == crwap_pkg::CRWAP_UNLOCK_IO && io_end)
             || (mode_q == crwap_pkg::CRWAP_UNLOCK_SPM && spm_end)) begin
            mode_d = crwap_pkg::CRWAP_UNLOCK_NONE;
            cnt_d  = 3'h0;
         end else if (evt_in.insn_done) begin
            cnt_d = cnt_q - 3'h1;
            if (cnt_q == 3'h1) begin
               mode_d = crwap_pkg::CRWAP_UNLOCK_NONE;
            end
         end
      end
      // key write after the cancel check so a fresh key reopens the window
      if (bus_req_in.wr && HIT(bus_req_in, crwap_pkg::OFS_KEY)) begin
         if (bus_req_in.wdata == crwap_pkg::SIG_IO_UNLOCK) begin
            mode_d = crwap_pkg::CRWAP_UNLOCK_IO;
            cnt_d  = crwap_pkg::UNLOCK_INSNS;
         end else if (bus_req_in.wdata == crwap_pkg::SIG_SPM_UNLOCK) begin
            mode_d = crwap_pkg::CRWAP_UNLOCK_SPM;
            cnt_d  = crwap_pkg::UNLOCK_INSNS;
         end
      end
      if (bus_req_in.wr && HIT(bus_req_in, crwap_pkg::OFS_FLAGS)) begin
         flags_d = bus_req_in.wdata;
      end
      // interrupts stay pending in their sources until the window closes
      irq_d = irq_pending_in && (mode_d == crwap_pkg::CRWAP_UNLOCK_NONE)
              && (mode_q == crwap_pkg::CRWAP_UNLOCK_NONE);
      io_d  = (mode_d == crwap_pkg::CRWAP_UNLOCK_IO);
      spm_d = (mode_d == crwap_pkg::CRWAP_UNLOCK_SPM);
      rdata_d = crwap_pkg::BYTE_ZERO;
      if (bus_req_in.rd) begin
         case (bus_req_in.addr)
            crwap_pkg::OFS_KEY: begin
               rdata_d[crwap_pkg::KEY_IO_BIT]  = (mode_q == crwap_pkg::CRWAP_UNLOCK_IO);
               rdata_d[crwap_pkg::KEY_SPM_BIT] = (mode_q == crwap_pkg::CRWAP_UNLOCK_SPM);
            end
            crwap_pkg::OFS_SP_LO, crwap_pkg::OFS_SP_HI: begin
               rdata_d = sp_rdata;
            end
            crwap_pkg::OFS_FLAGS: begin
               rdata_d = flags_q;
            end
            default: begin
               rdata_d = crwap_pkg::BYTE_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < crwap_pkg::NUM_REGS; i++) begin
            regs_q[i] <= crwap_pkg::BYTE_ZERO;
         end
         rd_a_q      <= crwap_pkg::BYTE_ZERO;
         rd_b_q      <= crwap_pkg::BYTE_ZERO;
         refused_q   <= 1'b0;
         ptr_addr_q  <= 16'h0000;
         prog_addr_q <= 16'h0000;
      end else begin
         for (int i = 0; i < crwap_pkg::NUM_REGS; i++) begin
            regs_q[i] <= regs_d[i];
         end
         rd_a_q      <= rd_a_d;
         rd_b_q      <= rd_b_d;
         refused_q   <= refused_d;
         ptr_addr_q  <= ptr_addr_d;
         prog_addr_q <= prog_addr_d;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_q    <= crwap_pkg::CRWAP_UNLOCK_NONE;
         cnt_q     <= 3'h0;
         flags_q   <= crwap_pkg::FLAGS_RESET;
         rdata_q   <= crwap_pkg::BYTE_ZERO;
         acc_io_q  <= 1'b0;
         acc_nvm_q <= 1'b0;
         irq_q     <= 1'b0;
         io_q      <= 1'b0;
         spm_q     <= 1'b0;
      end else begin
         mode_q    <= mode_d;
         cnt_q     <= cnt_d;
         flags_q   <= flags_d;
         rdata_q   <= rdata_d;
         acc_io_q  <= acc_io_d;
         acc_nvm_q <= acc_nvm_d;
         irq_q     <= irq_d;
         io_q      <= io_d;
         spm_q     <= spm_d;
      end
   end

   assign rd_a_out              = rd_a_q;
   assign rd_b_out              = rd_b_q;
   assign rf_refused_out        = refused_q;
   assign ptr_addr_out          = ptr_addr_q;
   assign prog_addr_out         = prog_addr_q;
   assign bus_rdata_out         = rdata_q;
   assign io_unlock_out         = io_q;
   assign spm_unlock_out        = spm_q;
   assign prot_io_accept_out    = acc_io_q;
   assign nvm_cmd_accept_out    = acc_nvm_q;
   assign irq_take_out          = irq_q;
   assign stack_top_pointer_out = sp_value;
   assign result_flags_out      = flags_q;
endmodule

// ==== rtl/crwap_pkg.sv ====
package crwap_pkg;
   // register file geometry
   localparam int unsigned NUM_REGS = 32;
   localparam int unsigned REG_W    = 8;
   localparam int unsigned RIDX_W   = 5;
   localparam logic [4:0]  IMM_BASE = 5'h10;
   localparam logic [4:0]  PTR_X_LO = 5'h1A;
   localparam logic [4:0]  PTR_Y_LO = 5'h1C;
   localparam logic [4:0]  PTR_Z_LO = 5'h1E;

   // cpu i/o register offsets
   localparam logic [5:0] OFS_KEY   = 6'h04;
   localparam logic [5:0] OFS_SP_LO = 6'h0D;
   localparam logic [5:0] OFS_SP_HI = 6'h0E;
   localparam logic [5:0] OFS_FLAGS = 6'h0F;

   // protection key
   localparam logic [7:0] SIG_IO_UNLOCK  = 8'hD8;
   localparam logic [7:0] SIG_SPM_UNLOCK = 8'h9D;
   localparam int unsigned KEY_IO_BIT    = 0;
   localparam int unsigned KEY_SPM_BIT   = 1;
   localparam logic [2:0] UNLOCK_INSNS   = 3'h4;
   localparam logic [7:0] FLAGS_RESET    = 8'h00;
   localparam logic [15:0] SP_RESET      = 16'h3FFF;
   localparam logic [7:0] BYTE_ZERO      = 8'h00;

   // pointer update selection
   typedef enum logic [1:0] {
      CRWAP_PTR_DISP,
      CRWAP_PTR_POSTINC,
      CRWAP_PTR_PREDEC
   } crwap_ptr_mode_t;

   typedef enum logic [1:0] {
      CRWAP_UNLOCK_NONE,
      CRWAP_UNLOCK_IO,
      CRWAP_UNLOCK_SPM
   } crwap_unlock_t;

   // register file port from the core
   typedef struct packed {
      logic        wr_en;
      logic [4:0]  wr_idx;
      logic [7:0]  wr_data;
      logic        imm_op;
      logic [4:0]  rd_a_idx;
      logic [4:0]  rd_b_idx;
   } crwap_rf_req_t;

   // pointer operation from the core
   typedef struct packed {
      logic            en;
      logic [1:0]      sel;
      crwap_ptr_mode_t mode;
      logic [5:0]      disp;
   } crwap_ptr_req_t;

   // byte-wide peripheral bus access
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } crwap_bus_req_t;

   // core activity that ends or uses an unlock
   typedef struct packed {
      logic insn_done;
      logic io_or_ram_wr;
      logic nvm_access;
      logic sleep_exec;
      logic nvm_cmd_wr;
      logic prot_io_wr;
   } crwap_core_evt_t;
endpackage

// ==== rtl/crwap_wide_stage.sv ====
`timescale 1ns/10ps
// 16-bit peripheral register behind a shared staging byte
module crwap_wide_stage (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        nrst_in,
   // byte accesses decoded by the owner
   input  wire logic        lo_wr_in,
   input  wire logic        hi_wr_in,
   input  wire logic        lo_rd_in,
   input  wire logic        hi_rd_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic [15:0] reset_val_in,
   // 16-bit result and byte read data
   output logic      [15:0] value_out,
   output logic      [7:0]  rdata_out
);
   logic [15:0] value_q;
   logic [15:0] value_d;
   logic [7:0]  stage_q;
   logic [7:0]  stage_d;
   logic        init_q;

   always_comb begin
      value_d = value_q;
      stage_d = stage_q;
      if (lo_wr_in) begin
         stage_d = wdata_in;
      end
      if (hi_wr_in) begin
         value_d = {wdata_in, stage_q};
      end
      if (lo_rd_in) begin
         stage_d = value_q[15:8];
      end
      rdata_out = BYTE_SEL(lo_rd_in, hi_rd_in);
   end

   function automatic logic [7:0] BYTE_SEL(input logic lo, input logic hi);
      if (lo) begin
         return value_q[7:0];
      end else if (hi) begin
         return stage_q;
      end
      return crwap_pkg::BYTE_ZERO;
   endfunction

   // reset value is a port, so it is caught on the first clock after release
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         value_q <= 16'h0000;
         stage_q <= crwap_pkg::BYTE_ZERO;
         init_q  <= 1'b0;
      end else if (!init_q) begin
         value_q <= reset_val_in;
         init_q  <= 1'b1;
      end else begin
         value_q <= value_d;
         stage_q <= stage_d;
      end
   end

   assign value_out = value_q;
endmodule

// ==== testbench/crwap_core_regs_properties.sv ====
`timescale 1ns/10ps
module crwap_core_regs_properties (
   // clock and reset
   input wire logic                       clock_in,
   input wire logic                       nrst_in,
   // watched inputs
   input wire crwap_pkg::crwap_rf_req_t   rf_req_in,
   input wire crwap_pkg::crwap_bus_req_t  bus_req_in,
   input wire crwap_pkg::crwap_core_evt_t evt_in,
   // watched outputs
   input wire logic                       rf_refused_out,
   input wire logic [7:0]                 bus_rdata_out,
   input wire logic                       io_unlock_out,
   input wire logic                       spm_unlock_out,
   input wire logic                       prot_io_accept_out,
   input wire logic                       nvm_cmd_accept_out,
   input wire logic                       irq_take_out,
   input wire logic [15:0]                stack_top_pointer_out
);
   wire        kw  = bus_req_in.wr && bus_req_in.addr == crwap_pkg::OFS_KEY;
   wire        opn = io_unlock_out || spm_unlock_out;
   wire        slo = bus_req_in.addr == crwap_pkg::OFS_SP_LO;
   wire        shi = bus_req_in.addr == crwap_pkg::OFS_SP_HI;
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   // retired instructions while unlocked since the last key write, saturating
   always_comb begin
      cnt_d = cnt_q;
      if (kw) begin
         cnt_d = 3'h0;
      end else if (opn && evt_in.insn_done && cnt_q != 3'h7) begin
         cnt_d = cnt_q + 3'h1;
      end
   end
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!nrst_in);
   a_imm_refuse: assert property (rf_req_in.wr_en && rf_req_in.imm_op &&
      rf_req_in.wr_idx < crwap_pkg::IMM_BASE |=> rf_refused_out) else $error("low imm write kept");
   a_key_io: assert property (kw && bus_req_in.wdata == crwap_pkg::SIG_IO_UNLOCK
      |=> io_unlock_out && !spm_unlock_out) else $error("io key did not open");
   a_key_spm: assert property (kw && bus_req_in.wdata == crwap_pkg::SIG_SPM_UNLOCK
      |=> spm_unlock_out && !io_unlock_out) else $error("spm key did not open");
   a_irq_held: assert property (opn |-> !irq_take_out)
      else $error("interrupt taken while unlocked");
   a_window_len: assert property (opn |-> cnt_q < 3'h4)
      else $error("window outlived four instructions");
   a_window_hold: assert property (io_unlock_out && !bus_req_in.wr &&
      evt_in == '0 |=> io_unlock_out) else $error("window closed early");
   a_io_cancel: assert property (io_unlock_out && evt_in.io_or_ram_wr && !kw
      |=> !io_unlock_out) else $error("io window survived write");
   a_spm_cancel: assert property (spm_unlock_out && !kw &&
      (evt_in.nvm_access || evt_in.sleep_exec) |=> !spm_unlock_out) else $error("spm kept");
   a_io_accept: assert property (prot_io_accept_out |->
      $past(io_unlock_out) && $past(evt_in.prot_io_wr)) else $error("io write accepted locked");
   a_nvm_accept: assert property (nvm_cmd_accept_out |->
      $past(spm_unlock_out) && $past(evt_in.nvm_cmd_wr)) else $error("nvm cmd accepted locked");
   a_key_read: assert property (bus_req_in.rd && bus_req_in.addr == crwap_pkg::OFS_KEY |=>
      bus_rdata_out == {6'h00, $past(spm_unlock_out), $past(io_unlock_out)}) else $error("key read");
   a_lo_write: assert property (bus_req_in.wr && slo |=> $stable(stack_top_pointer_out))
      else $error("low write reached pointer");
   a_hi_commit: assert property (bus_req_in.wr && slo ##1 bus_req_in.wr && shi |=>
      stack_top_pointer_out == {$past(bus_req_in.wdata), $past(bus_req_in.wdata, 2)})
      else $error("pointer pair not committed");
   a_lo_read: assert property (bus_req_in.rd && slo |=>
      bus_rdata_out == $past(stack_top_pointer_out[7:0])) else $error("low read wrong");
   c_io_accept: cover property (prot_io_accept_out);
   c_nvm_accept: cover property (nvm_cmd_accept_out);
   c_refuse: cover property (rf_refused_out);
endmodule
bind crwap_core_regs crwap_core_regs_properties crwap_core_regs_properties_inst (
   .clock_in(clock_in), .nrst_in(nrst_in), .rf_req_in(rf_req_in), .bus_req_in(bus_req_in),
   .evt_in(evt_in), .rf_refused_out(rf_refused_out), .bus_rdata_out(bus_rdata_out),
   .io_unlock_out(io_unlock_out), .spm_unlock_out(spm_unlock_out),
   .prot_io_accept_out(prot_io_accept_out), .nvm_cmd_accept_out(nvm_cmd_accept_out),
   .irq_take_out(irq_take_out), .stack_top_pointer_out(stack_top_pointer_out));

// ==== testbench/crwap_core_model.sv ====
`timescale 1ns/10ps
module crwap_core_model (
   // clock and reset
   input  wire logic clock_in,
   input  wire logic nrst_in,
   // pace: one instruction every third cycle when set
   input  wire logic slow_in,
   // retire strobe
   output logic      insn_done_out
);
   logic [1:0] ph;
   // falling edge keeps the strobe clear of the sampling edge
   always @(negedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ph <= 2'h0;
         insn_done_out <= 1'b0;
      end else begin
         ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
         insn_done_out <= !slow_in || ph == 2'h0;
      end
   end
endmodule

// ==== testbench/crwap_core_regs_tb.sv ====
`timescale 1ns/10ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module crwap_core_regs_tb;
   logic                       clock_in = 1'b0;
   logic                       nrst_in  = 1'b0;
   logic                       slow     = 1'b0;
   logic                       irq      = 1'b1;
   logic                       rchk     = 1'b0;
   logic                       insn;
   crwap_pkg::crwap_rf_req_t   rf  = '0;
   crwap_pkg::crwap_ptr_req_t  ptr = '0;
   crwap_pkg::crwap_bus_req_t  bus = '0;
   crwap_pkg::crwap_core_evt_t ev  = '0;
   crwap_pkg::crwap_core_evt_t evt;
   logic [7:0]                 rda, rdb, brd, flg, x, y;
   logic                       refd, iou, spu, pacc, nacc, itake;
   logic [15:0]                pa, za, sp;
   logic [7:0]                 m [32];
   logic [7:0]                 bq [$];
   logic [15:0]                rq [$];
   int                         error_cnt = 0;
   int                         tests_run = 0;
   assign evt = crwap_pkg::crwap_core_evt_t'(ev | {insn, 5'h00});
   always #5 clock_in = ~clock_in;
   crwap_core_model crwap_core_model_inst (.clock_in(clock_in), .nrst_in(nrst_in),
      .slow_in(slow), .insn_done_out(insn));
   crwap_core_regs crwap_core_regs_inst (.clock_in(clock_in), .nrst_in(nrst_in),
      .rf_req_in(rf), .ptr_req_in(ptr), .bus_req_in(bus), .evt_in(evt), .irq_pending_in(irq),
      .rd_a_out(rda), .rd_b_out(rdb), .rf_refused_out(refd), .ptr_addr_out(pa),
      .prog_addr_out(za), .bus_rdata_out(brd), .io_unlock_out(iou), .spm_unlock_out(spu),
      .prot_io_accept_out(pacc), .nvm_cmd_accept_out(nacc), .irq_take_out(itake),
      .stack_top_pointer_out(sp), .result_flags_out(flg));
   // monitor: results land one edge after the request
   always @(posedge clock_in) begin
      logic        b, r;
      logic [7:0]  e8;
      logic [15:0] e16;
      b = bus.rd;
      r = rchk;
      #1;
      if (b) begin
         e8 = bq.pop_front();
         `CHK("bus_rdata", e8, brd)
      end
      if (r) begin
         e16 = rq.pop_front();
         `CHK("rf_read", e16, {rda, rdb})
      end
   end
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic bus_op(input logic r, w, input logic [5:0] a, input logic [7:0] d);
      @(negedge clock_in);
      bus = '{rd: r, wr: w, addr: a, wdata: d};
   endtask
   task automatic idle;
      bus_op(1'b0, 1'b0, 6'h00, 8'h00);
   endtask
   task automatic rd_exp(input logic [5:0] a, input logic [7:0] e);
      bus_op(1'b1, 1'b0, a, 8'h00);
      bq.push_back(e);
   endtask
   task automatic rf_w(input logic [4:0] i, input logic [7:0] d, input logic imm);
      @(negedge clock_in);
      rf = '{wr_en: 1'b1, wr_idx: i, wr_data: d, imm_op: imm, rd_a_idx: 5'h00, rd_b_idx: 5'h00};
      if (!imm || i >= crwap_pkg::IMM_BASE) m[i] = d;
   endtask
   task automatic rd_all;
      for (int i = 0; i < 32; i++) begin
         @(negedge clock_in);
         rf = '{wr_en: 1'b0, wr_idx: 5'h00, wr_data: 8'h00, imm_op: 1'b0,
                rd_a_idx: 5'(i), rd_b_idx: 5'(31 - i)};
         rchk = 1'b1;
         rq.push_back({m[i], m[31 - i]});
      end
      @(negedge clock_in);
      rchk = 1'b0;
   endtask
   task automatic ptr_op(input logic [1:0] s, input crwap_pkg::crwap_ptr_mode_t md,
                         input logic [5:0] dp);
      logic [4:0]  lo;
      logic [15:0] p, e;
      lo = 5'(26 + 2 * s);
      p = {m[lo + 5'h01], m[lo]};
      e = md == crwap_pkg::CRWAP_PTR_DISP ? p + 16'(dp) :
          md == crwap_pkg::CRWAP_PTR_POSTINC ? p : p - 16'h0001;
      if (md == crwap_pkg::CRWAP_PTR_POSTINC) p = p + 16'h0001;
      else if (md == crwap_pkg::CRWAP_PTR_PREDEC) p = e;
      {m[lo + 5'h01], m[lo]} = p;
      @(negedge clock_in);
      rf = '0;
      ptr = '{en: 1'b1, sel: s, mode: md, disp: dp};
      @(posedge clock_in);
      #1;
      `CHK("ptr_addr", e, pa)
   endtask
   // key write, optional cancel, dly idle cycles, then the protected action
   task automatic prot(input logic [7:0] k, input int dly, input crwap_pkg::crwap_core_evt_t cx,
                       input logic ei, en);
      bus_op(1'b0, 1'b1, crwap_pkg::OFS_KEY, k);
      @(negedge clock_in);
      bus = '0;
      ev = cx;
      repeat (dly) @(negedge clock_in);
      @(negedge clock_in);
      ev = crwap_pkg::crwap_core_evt_t'({4'h0, k == crwap_pkg::SIG_SPM_UNLOCK,
                                         k == crwap_pkg::SIG_IO_UNLOCK});
      @(posedge clock_in);
      #1;
      `CHK("io_accept", ei, pacc)
      `CHK("nvm_accept", en, nacc)
      @(negedge clock_in);
      ev = '0;
      repeat (14) @(negedge clock_in);
      `CHK("irq_take", 1'b1, itake)
   endtask
   initial begin
      #500000;
      error_cnt++;
      stop_test();
   end
   initial begin
      void'($urandom(32'h0000FD6B));
      repeat (10) @(negedge clock_in);
      nrst_in = 1'b1;
      repeat (2) @(posedge clock_in);
      #1;
      `CHK("sp_reset", crwap_pkg::SP_RESET, sp)
      for (int i = 0; i < 32; i++) rf_w(5'(i), 8'($urandom), 1'b0);
      rf_w(5'h0F, 8'hA5, 1'b1);
      rf_w(5'h10, 8'h5A, 1'b1);
      `CHK("refused", 1'b1, refd)
      rd_all();
      for (int s = 0; s < 3; s++) begin
         ptr_op(2'(s), crwap_pkg::CRWAP_PTR_DISP, 6'($urandom));
         ptr_op(2'(s), crwap_pkg::CRWAP_PTR_POSTINC, 6'h00);
         ptr_op(2'(s), crwap_pkg::CRWAP_PTR_PREDEC, 6'h00);
         ptr_op(2'(s), crwap_pkg::CRWAP_PTR_PREDEC, 6'h00);
      end
      @(negedge clock_in);
      ptr = '0;
      @(negedge clock_in);
      `CHK("prog_addr", {m[31], m[30]}, za)
      rd_all();
      x = 8'($urandom);
      y = 8'($urandom);
      bus_op(1'b0, 1'b1, crwap_pkg::OFS_SP_LO, x);
      bus_op(1'b0, 1'b1, crwap_pkg::OFS_SP_HI, y);
      `CHK("sp_lo_only", crwap_pkg::SP_RESET, sp)
      idle();
      `CHK("sp_commit", {y, x}, sp)
      rd_exp(crwap_pkg::OFS_SP_LO, x);
      rd_exp(crwap_pkg::OFS_SP_HI, y);
      bus_op(1'b0, 1'b1, crwap_pkg::OFS_SP_LO, ~x);
      rd_exp(crwap_pkg::OFS_SP_HI, ~x);
      bus_op(1'b0, 1'b1, crwap_pkg::OFS_FLAGS, y);
      bus_op(1'b0, 1'b1, 6'h20, x);
      `CHK("flags", y, flg)
      rd_exp(crwap_pkg::OFS_FLAGS, y);
      rd_exp(6'h20, 8'h00);
      rd_exp(6'h01, 8'h00);
      for (int j = 0; j < 2; j++) begin
         bus_op(1'b0, 1'b1, crwap_pkg::OFS_KEY,
                j ? crwap_pkg::SIG_SPM_UNLOCK : crwap_pkg::SIG_IO_UNLOCK);
         rd_exp(crwap_pkg::OFS_KEY, 8'(j + 1));
         `CHK("unlock_open", 2'(j + 1), {spu, iou})
         idle();
         repeat (8) @(negedge clock_in);
         `CHK("unlock_shut", 2'h0, {spu, iou})
         rd_exp(crwap_pkg::OFS_KEY, 8'h00);
         idle();
      end
      prot(crwap_pkg::SIG_IO_UNLOCK, 1, '0, 1'b1, 1'b0);
      prot(crwap_pkg::SIG_IO_UNLOCK, 4, '0, 1'b0, 1'b0);
      slow <= 1'b1;
      prot(crwap_pkg::SIG_IO_UNLOCK, 4, '0, 1'b1, 1'b0);
      slow <= 1'b0;
      prot(crwap_pkg::SIG_IO_UNLOCK, 0, 6'h10, 1'b0, 1'b0);
      prot(crwap_pkg::SIG_IO_UNLOCK, 0, 6'h04, 1'b0, 1'b0);
      prot(crwap_pkg::SIG_SPM_UNLOCK, 1, '0, 1'b0, 1'b1);
      prot(crwap_pkg::SIG_SPM_UNLOCK, 0, 6'h10, 1'b0, 1'b1);
      prot(crwap_pkg::SIG_SPM_UNLOCK, 0, 6'h08, 1'b0, 1'b0);
      prot(8'h55, 0, '0, 1'b0, 1'b0);
      repeat (5) @(negedge clock_in);
      stop_test();
   end
endmodule
